// [threshold_code_params.svh]
// Constants for the supply detector control block: offsets, fields, resets, counts.
// Assumes inclusion by the package, the design module and the bench.
`ifndef THRESHOLD_CODE_PARAMS_SVH
`define THRESHOLD_CODE_PARAMS_SVH
`define THRESHOLD_CODE_OFS_CLK 12'h000
`define THRESHOLD_CODE_OFS_CTL 12'h004
`define THRESHOLD_CODE_OFS_FLAG 12'h008
`define THRESHOLD_CODE_OFS_IEN 12'h00c
`define THRESHOLD_CODE_OFS_PROT 12'h010
`define THRESHOLD_CODE_PROT_KEY 16'h0096
`define THRESHOLD_CODE_RST_CODE 4'ha
`define THRESHOLD_CODE_CLK_RESET 16'h0100
`define THRESHOLD_CODE_CTL_RESET 16'h1e00
`define THRESHOLD_CODE_THR_RESET 5'h1e
`define THRESHOLD_CODE_CLK_DEBUG_RUN 8
`define THRESHOLD_CODE_CTL_SOURCE_SELECT 15
`define THRESHOLD_CODE_CTL_SC_LO 13
`define THRESHOLD_CODE_CTL_THR_LO 8
`define THRESHOLD_CODE_CTL_RE_LO 4
`define THRESHOLD_CODE_CTL_EXTERNAL_PIN_SELECT 3
`define THRESHOLD_CODE_CTL_MD_LO 1
`define THRESHOLD_CODE_FLAG_DT 8
`define THRESHOLD_CODE_DIS_CYCLES 4'h3
`endif

// [threshold_code_pkg.sv]
// Types shared by the supply detector control block.
// Assumes threshold_code_params.svh sits in the include path.
package threshold_code_pkg;
`include "threshold_code_params.svh"
   typedef enum logic [1:0] {
      THRESHOLD_CODE_IDLE = 2'b00,
      THRESHOLD_CODE_RUN = 2'b01,
      THRESHOLD_CODE_RST = 2'b11,
      THRESHOLD_CODE_STOP = 2'b10
   } threshold_code_state_t;
endpackage

// [threshold_code_ctrl.sv]
// Supply detector control: AXI4-Lite registers, sampling, count, flag and reset issuance.
// Assumes a comparator result on cmp_low synchronous to aclk and external clock mux/divider.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "threshold_code_params.svh"

module threshold_code_ctrl
   import threshold_code_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic det_clk_tick,
   input wire logic debug_halt,
   input wire logic cmp_low,
   output logic det_power_on,
   output logic src_ext_sel,
   output logic ext_pin_b_sel,
   output logic ext_route_keep,
   output logic [4:0] threshold_code,
   output logic [1:0] clock_source_sel,
   output logic [2:0] clock_divider_sel,
   output logic det_clk_run,
   output logic irq_req,
   output logic sys_reset_req
);
   // Registers
   logic [15:0] prot_r;
   logic debug_run_r;
   logic [2:0] clock_divider_sel_r;
   logic [1:0] clock_source_sel_r;
   logic source_select_r;
   logic [1:0] successive_count_sel_r;
   logic [4:0] threshold_code_r;
   logic [3:0] reset_select_r;
   logic external_pin_select_r;
   logic [1:0] sampling_mode_sel_r;
   logic detect_enable_r;
   logic low_voltage_result_r;
   logic low_voltage_irq_flag_r;
   logic low_voltage_irq_enable_r;
   logic sys_reset_r;
   threshold_code_state_t state_r;
   logic [8:0] period_cnt_r;
   logic [3:0] low_cnt_r;
   logic [3:0] dis_cnt_r;
   logic reinit_r;
   logic power_r;

   // Bus state
   logic aw_have_r;
   logic w_have_r;
   logic [11:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic rvalid_r;
   logic [31:0] rdata_r;

   logic unlocked;
   logic wr_fire;
   logic wr_lo;
   logic wr_hi;
   logic [15:0] wd;
   logic tick;
   logic period_end;
   logic sample;
   logic low_event;
   logic in_reset;
   logic eff_intermittent;
   logic [3:0] need_cnt;

   // Last interval count (period length minus one tick) for intermittent mode codes
   function automatic logic [8:0] threshold_code_period(input logic [1:0] md);
      case (md)
         2'h1: threshold_code_period = 9'd127;
         2'h2: threshold_code_period = 9'd255;
         default: threshold_code_period = 9'd511;
      endcase
   endfunction

   // Successive low samples needed per count code
   function automatic logic [3:0] threshold_code_need(input logic [1:0] sc);
      case (sc)
         2'h0: threshold_code_need = 4'h1;
         2'h1: threshold_code_need = 4'h2;
         2'h2: threshold_code_need = 4'h4;
         default: threshold_code_need = 4'h8;
      endcase
   endfunction

   assign unlocked = (prot_r == `THRESHOLD_CODE_PROT_KEY);
   assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
   assign wr_lo = w_strb_r[0];
   assign wr_hi = w_strb_r[1];
   assign wd = w_data_r[15:0];
   assign in_reset = (state_r == THRESHOLD_CODE_RST);
   assign tick = det_clk_tick && (debug_run_r || !debug_halt);
   assign eff_intermittent = (sampling_mode_sel_r != 2'h0) && !in_reset;
   assign period_end = (period_cnt_r == threshold_code_period(sampling_mode_sel_r));
   // Only sample once the detector has been powered for a full tick
   assign sample = tick && !reinit_r && power_r && (state_r == THRESHOLD_CODE_RUN || in_reset)
      && (eff_intermittent ? period_end : 1'b1);
   assign need_cnt = eff_intermittent ? threshold_code_need(successive_count_sel_r) : 4'h1;
   assign low_event = sample && cmp_low && (low_cnt_r + 4'h1 >= need_cnt);

   // Write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Write response, unmapped writes answered SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         s_axi_bresp <= (aw_addr_r > `THRESHOLD_CODE_OFS_PROT || aw_addr_r[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= s_axi_awvalid && !aw_have_r && !s_axi_awready;
         s_axi_wready <= s_axi_wvalid && !w_have_r && !s_axi_wready;
      end
   end

   // Protection key register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_r <= 16'h0000;
      end else if (wr_fire && aw_addr_r == `THRESHOLD_CODE_OFS_PROT) begin
         if (wr_lo) prot_r[7:0] <= wd[7:0];
         if (wr_hi) prot_r[15:8] <= wd[15:8];
      end
   end

   // Clock control, forced to initial values during detector reset
   always_ff @(posedge aclk) begin
      if (!aresetn || in_reset) begin
         debug_run_r <= 1'(`THRESHOLD_CODE_CLK_RESET >> `THRESHOLD_CODE_CLK_DEBUG_RUN);
         clock_divider_sel_r <= 3'h0;
         clock_source_sel_r <= 2'h0;
      end else if (wr_fire && unlocked && aw_addr_r == `THRESHOLD_CODE_OFS_CLK) begin
         if (wr_hi) debug_run_r <= wd[`THRESHOLD_CODE_CLK_DEBUG_RUN];
         if (wr_lo) clock_divider_sel_r <= wd[6:4];
         if (wr_lo) clock_source_sel_r <= wd[1:0];
      end
   end

   // Detector control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_select_r <= 1'b0;
         successive_count_sel_r <= 2'h0;
         threshold_code_r <= `THRESHOLD_CODE_THR_RESET;
         reset_select_r <= 4'h0;
         external_pin_select_r <= 1'b0;
         sampling_mode_sel_r <= 2'h0;
      end else if (in_reset) begin
         sampling_mode_sel_r <= 2'h0;
         successive_count_sel_r <= 2'h0;
      end else if (wr_fire && unlocked && aw_addr_r == `THRESHOLD_CODE_OFS_CTL) begin
         if (wr_hi) begin
            source_select_r <= wd[`THRESHOLD_CODE_CTL_SOURCE_SELECT];
            threshold_code_r <= wd[`THRESHOLD_CODE_CTL_THR_LO +: 5];
            if (sampling_mode_sel_r != 2'h0) successive_count_sel_r <= wd[`THRESHOLD_CODE_CTL_SC_LO +: 2];
         end
         if (wr_lo) begin
            reset_select_r <= wd[`THRESHOLD_CODE_CTL_RE_LO +: 4];
            external_pin_select_r <= wd[`THRESHOLD_CODE_CTL_EXTERNAL_PIN_SELECT];
            sampling_mode_sel_r <= wd[`THRESHOLD_CODE_CTL_MD_LO +: 2];
         end
      end
   end

   // Enable bit and shutdown sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         detect_enable_r <= 1'b0;
         state_r <= THRESHOLD_CODE_IDLE;
         dis_cnt_r <= 4'h0;
      end else begin
         case (state_r)
            THRESHOLD_CODE_IDLE: begin
               if (wr_fire && unlocked && wr_lo && aw_addr_r == `THRESHOLD_CODE_OFS_CTL && wd[0]) begin
                  detect_enable_r <= 1'b1;
                  state_r <= THRESHOLD_CODE_RUN;
               end
            end
            THRESHOLD_CODE_RUN: begin
               if (wr_fire && unlocked && wr_lo && aw_addr_r == `THRESHOLD_CODE_OFS_CTL && !wd[0]) begin
                  state_r <= THRESHOLD_CODE_STOP;
                  dis_cnt_r <= `THRESHOLD_CODE_DIS_CYCLES;
               end else if (low_event && reset_select_r == `THRESHOLD_CODE_RST_CODE) begin
                  state_r <= THRESHOLD_CODE_RST;
               end
            end
            THRESHOLD_CODE_RST: begin
               if (sample && !cmp_low) state_r <= THRESHOLD_CODE_RUN;
            end
            default: begin
               if (dis_cnt_r == 4'h0) begin
                  detect_enable_r <= 1'b0;
                  state_r <= THRESHOLD_CODE_IDLE;
               end else begin
                  dis_cnt_r <= dis_cnt_r - 4'h1;
               end
            end
         endcase
      end
   end

   // Reinitialise detection when reset select, mode or count code changes or flag cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reinit_r <= 1'b0;
      end else begin
         reinit_r <= (state_r == THRESHOLD_CODE_RUN) && wr_fire && unlocked && (
            (aw_addr_r == `THRESHOLD_CODE_OFS_CTL && wr_lo && (wd[`THRESHOLD_CODE_CTL_RE_LO +: 4] != reset_select_r
               || wd[`THRESHOLD_CODE_CTL_MD_LO +: 2] != sampling_mode_sel_r))
            || (aw_addr_r == `THRESHOLD_CODE_OFS_CTL && wr_hi && sampling_mode_sel_r != 2'h0
               && wd[`THRESHOLD_CODE_CTL_SC_LO +: 2] != successive_count_sel_r));
         if ((state_r == THRESHOLD_CODE_RUN) && wr_fire && aw_addr_r == `THRESHOLD_CODE_OFS_FLAG && wr_lo && wd[0])
            reinit_r <= 1'b1;
      end
   end

   // Interval counter and power control
   always_ff @(posedge aclk) begin
      if (!aresetn || state_r == THRESHOLD_CODE_IDLE || state_r == THRESHOLD_CODE_STOP || reinit_r) begin
         period_cnt_r <= 9'h000;
         power_r <= 1'b0;
      end else if (tick) begin
         period_cnt_r <= period_end ? 9'h000 : period_cnt_r + 9'h001;
         power_r <= !eff_intermittent || (period_cnt_r == threshold_code_period(sampling_mode_sel_r) - 9'h001)
            || period_end;
      end
   end

   // Result latch and successive low counter
   always_ff @(posedge aclk) begin
      if (!aresetn || state_r == THRESHOLD_CODE_STOP || reinit_r) begin
         low_cnt_r <= 4'h0;
         if (!aresetn) low_voltage_result_r <= 1'b0;
      end else if (sample) begin
         low_voltage_result_r <= cmp_low;
         if (!cmp_low) low_cnt_r <= 4'h0;
         else if (low_event) low_cnt_r <= 4'h0;
         else low_cnt_r <= low_cnt_r + 4'h1;
      end
   end

   // Sticky flag, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_voltage_irq_flag_r <= 1'b0;
      end else if (low_event && reset_select_r != `THRESHOLD_CODE_RST_CODE && state_r == THRESHOLD_CODE_RUN) begin
         low_voltage_irq_flag_r <= 1'b1;
      end else if (wr_fire && aw_addr_r == `THRESHOLD_CODE_OFS_FLAG && wr_lo && wd[0]) begin
         low_voltage_irq_flag_r <= 1'b0;
      end
   end

   // Interrupt enable, cleared during detector reset
   always_ff @(posedge aclk) begin
      if (!aresetn || in_reset) begin
         low_voltage_irq_enable_r <= 1'b0;
      end else if (wr_fire && aw_addr_r == `THRESHOLD_CODE_OFS_IEN && wr_lo) begin
         low_voltage_irq_enable_r <= wd[0];
      end
   end

   // Registered pin-side outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req <= 1'b0;
         sys_reset_req <= 1'b0;
         det_power_on <= 1'b0;
         src_ext_sel <= 1'b0;
         ext_pin_b_sel <= 1'b0;
         ext_route_keep <= 1'b0;
         threshold_code <= `THRESHOLD_CODE_THR_RESET;
         clock_source_sel <= 2'h0;
         clock_divider_sel <= 3'h0;
         det_clk_run <= 1'b1;
      end else begin
         irq_req <= low_voltage_irq_flag_r && low_voltage_irq_enable_r;
         sys_reset_req <= in_reset;
         det_power_on <= power_r;
         src_ext_sel <= source_select_r;
         ext_pin_b_sel <= external_pin_select_r;
         ext_route_keep <= in_reset && source_select_r;
         threshold_code <= threshold_code_r;
         clock_source_sel <= clock_source_sel_r;
         clock_divider_sel <= clock_divider_sel_r;
         det_clk_run <= debug_run_r || !debug_halt;
      end
   end

   // Read channel, reserved bits zero, data offered after the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && !rvalid_r && !s_axi_arready) begin
         s_axi_arready <= 1'b1;
         s_axi_rresp <= 2'b00;
         if (s_axi_araddr == `THRESHOLD_CODE_OFS_CLK)
            rdata_r <= {23'h0, debug_run_r, 1'b0, clock_divider_sel_r, 2'h0, clock_source_sel_r};
         else if (s_axi_araddr == `THRESHOLD_CODE_OFS_CTL)
            rdata_r <= {16'h0, source_select_r, successive_count_sel_r, threshold_code_r,
               reset_select_r, external_pin_select_r, sampling_mode_sel_r, detect_enable_r};
         else if (s_axi_araddr == `THRESHOLD_CODE_OFS_FLAG)
            rdata_r <= {23'h0, low_voltage_result_r, 7'h0, low_voltage_irq_flag_r};
         else if (s_axi_araddr == `THRESHOLD_CODE_OFS_IEN)
            rdata_r <= {31'h0, low_voltage_irq_enable_r};
         else if (s_axi_araddr == `THRESHOLD_CODE_OFS_PROT)
            rdata_r <= {31'h0, unlocked};
         else begin
            rdata_r <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
         end
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) rvalid_r <= 1'b1;
         else if (rvalid_r && s_axi_rready) rvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
endmodule

// [threshold_code_cmp_model.sv]
// Far-side model: detector clock ticks and the analog comparator.
// Assumes the bench sets the sensed level; a larger level is a higher voltage.
`timescale 1ns/100ps
module threshold_code_cmp_model
   import threshold_code_pkg::*;
(
   input wire logic aclk,
   input wire logic det_power_on,
   input wire logic det_clk_run,
   input wire logic [4:0] threshold_code,
   input wire logic [5:0] level,
   output logic det_clk_tick,
   output logic cmp_low
);
   logic [1:0] div_r = 2'h0;
   logic tick_r = 1'b0;
   logic noise_r = 1'b0;
   // Tick every fourth cycle, frozen while the clock is gated
   always_ff @(posedge aclk) begin
      if (det_clk_run) div_r <= div_r + 2'h1;
      tick_r <= det_clk_run && (div_r == 2'h3);
      noise_r <= ~noise_r;
   end
   assign det_clk_tick = tick_r;
   // Unpowered comparator gives no trustworthy answer
   assign cmp_low = det_power_on ? (level < {1'b0, threshold_code}) : noise_r;
endmodule

// [threshold_code_ctrl_asserts.sv]
// Port-level checks for the supply detector control block.
// Assumes one clock aclk and synchronous active-low reset aresetn.
`timescale 1ns/100ps
module threshold_code_ctrl_asserts
   import threshold_code_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic debug_halt,
   input wire logic det_clk_tick,
   input wire logic cmp_low,
   input wire logic src_ext_sel,
   input wire logic ext_route_keep,
   input wire logic [4:0] threshold_code,
   input wire logic [1:0] clock_source_sel,
   input wire logic [2:0] clock_divider_sel,
   input wire logic det_clk_run,
   input wire logic irq_req,
   input wire logic sys_reset_req
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Write offered with no response pending
   sequence wr_offer;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   endsequence
   // Detector reset held for two cycles
   sequence rst_held;
      sys_reset_req [*2];
   endsequence
   // Sample at or above threshold during detector reset
   sequence low_gone;
      sys_reset_req && det_clk_tick && !cmp_low;
   endsequence
   reset_values_a: assert property ($rose(aresetn) |-> threshold_code == 5'h1e && det_clk_run)
      else $error("reset values wrong");
   write_resp_a: assert property (wr_offer |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   clock_run_a: assert property (!$past(debug_halt) |-> det_clk_run)
      else $error("detector clock gated outside debug");
   irq_masked_a: assert property (sys_reset_req [*3] |-> !irq_req)
      else $error("irq during detector reset");
   clock_init_a: assert property (rst_held |-> clock_source_sel == 2'h0 && clock_divider_sel == 3'h0)
      else $error("clock fields kept in reset");
   route_keep_a: assert property (rst_held |-> ext_route_keep == src_ext_sel)
      else $error("external route not kept");
   field_keep_a: assert property (rst_held |-> $stable(threshold_code) && $stable(src_ext_sel))
      else $error("kept fields changed in reset");
   reset_exit_a: assert property (low_gone |-> ##[1:4] !sys_reset_req)
      else $error("reset not released");
endmodule
bind threshold_code_ctrl threshold_code_ctrl_asserts threshold_code_ctrl_asserts_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .debug_halt, .det_clk_tick,
   .cmp_low,
   .src_ext_sel, .ext_route_keep, .threshold_code, .clock_source_sel, .clock_divider_sel, .det_clk_run,
   .irq_req, .sys_reset_req);

// [threshold_code_ctrl_bench.sv]
// Self-checking bench for the supply detector control block.
// Assumes the comparator model file and the checker are compiled alongside.
`timescale 1ns/100ps
`include "threshold_code_params.svh"
module threshold_code_ctrl_bench
   import threshold_code_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, debug_halt = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic [5:0] level = 6'h3f;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, det_clk_tick, cmp_low;
   logic det_power_on, src_ext_sel, ext_pin_b_sel, ext_route_keep, det_clk_run, irq_req, sys_reset_req;
   logic [1:0] s_axi_bresp, s_axi_rresp, clock_source_sel;
   logic [2:0] clock_divider_sel;
   logic [4:0] threshold_code;
   logic [33:0] exp_q[$];
   int err_total = 0, n_checks = 0;
   logic [1:0] last_bresp = 2'h0;
   threshold_code_ctrl threshold_code_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .det_clk_tick,
      .debug_halt, .cmp_low, .det_power_on, .src_ext_sel, .ext_pin_b_sel, .ext_route_keep, .threshold_code,
      .clock_source_sel, .clock_divider_sel, .det_clk_run, .irq_req, .sys_reset_req);
   threshold_code_cmp_model threshold_code_cmp_model_i (.aclk, .det_power_on, .det_clk_run, .threshold_code, .level,
      .det_clk_tick, .cmp_low);
   // 50 ns clock
   initial begin
      forever #25 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tmo;
      err_total++;
      summarize();
   endtask
   // Write: address and data together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      last_bresp = s_axi_bresp;
      if (n >= 50) tmo();
   endtask
   // Read: expected response noted for the monitor
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n >= 50) tmo();
   endtask
   task automatic wait_sig(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge aclk);
         n++;
      end
      if (s !== v) tmo();
   endtask
   // Read monitor compares against the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         if (exp_q.size() == 0) chk("unexpected read", 34'h1, 34'h0);
         else chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   // Main sequence
   initial begin
      int i, n, cnt, per, t0;
      logic [31:0] v;
      logic [4:0] thr;
      logic [1:0] md;
      logic pw;
      void'($urandom(77551));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`THRESHOLD_CODE_OFS_CLK, {18'h0, `THRESHOLD_CODE_CLK_RESET});
      rd(`THRESHOLD_CODE_OFS_CTL, {18'h0, `THRESHOLD_CODE_CTL_RESET});
      rd(12'h020, {2'h2, 32'h0});
      wr(12'h020, 32'h1);
      chk("bresp unmapped", {32'h0, last_bresp}, {32'h0, 2'h2});
      wr(`THRESHOLD_CODE_OFS_CTL, 32'h1);
      rd(`THRESHOLD_CODE_OFS_CTL, {18'h0, `THRESHOLD_CODE_CTL_RESET});
      wr(`THRESHOLD_CODE_OFS_PROT, {16'h0, `THRESHOLD_CODE_PROT_KEY});
      chk("bresp okay", {32'h0, last_bresp}, 34'h0);
      rd(`THRESHOLD_CODE_OFS_PROT, 34'h1);
      v = $urandom;
      wr(`THRESHOLD_CODE_OFS_CLK, v);
      rd(`THRESHOLD_CODE_OFS_CLK, {2'h0, v & 32'h173});
      @(negedge aclk);
      chk("source", {32'h0, clock_source_sel}, {32'h0, v[1:0]});
      chk("divider", {31'h0, clock_divider_sel}, {31'h0, v[6:4]});
      // Continuous detection with flag and interrupt
      thr = 5'($urandom_range(31, 1));
      wr(`THRESHOLD_CODE_OFS_CTL, {16'h0, 1'b1, 2'h3, thr, 4'h0, 1'b1, 2'h0, 1'b1});
      rd(`THRESHOLD_CODE_OFS_CTL, {18'h0, 1'b1, 2'h0, thr, 4'h0, 1'b1, 2'h0, 1'b1});
      @(negedge aclk);
      chk("pins", {27'h0, thr, src_ext_sel, ext_pin_b_sel}, {27'h0, thr, 2'h3});
      wr(`THRESHOLD_CODE_OFS_IEN, 32'h1);
      level <= {1'b0, thr - 5'h1};
      wait_sig(irq_req, 1'b1, 200);
      rd(`THRESHOLD_CODE_OFS_FLAG, 34'h101);
      level <= 6'h3f;
      wr(`THRESHOLD_CODE_OFS_IEN, 32'h0);
      @(negedge aclk);
      chk("irq masked", {33'h0, irq_req}, 34'h0);
      wr(`THRESHOLD_CODE_OFS_FLAG, 32'h0);
      rd(`THRESHOLD_CODE_OFS_FLAG, 34'h001);
      wr(`THRESHOLD_CODE_OFS_FLAG, 32'h1);
      rd(`THRESHOLD_CODE_OFS_FLAG, 34'h000);
      wr(`THRESHOLD_CODE_OFS_IEN, 32'h1);
      // Intermittent periods and successive counts
      for (i = 0; i < 4; i++) begin
         md = 2'(i % 3 + 1);
         level <= 6'h3f;
         wr(`THRESHOLD_CODE_OFS_CTL, {16'h0, 1'b0, i[1:0], thr, 4'h0, 1'b0, md, 1'b1});
         wr(`THRESHOLD_CODE_OFS_FLAG, 32'h1);
         level <= 6'h00;
         // Let the cleared flag reach irq_req before watching it
         @(posedge aclk);
         n = 0;
         cnt = 0;
         t0 = 0;
         per = 0;
         pw = det_power_on;
         while (!irq_req && n < 20000) begin
            @(posedge aclk);
            n++;
            if (det_power_on && !pw) begin
               cnt++;
               per = n - t0;
               t0 = n;
            end
            pw = det_power_on;
         end
         if (!irq_req) tmo();
         chk("samples", 34'(cnt), 34'(1 << i));
         if (i > 0) chk("period", 34'(per), 34'(512 << (md - 1)));
      end
      // Reset issuance and the reset state
      level <= 6'h3f;
      wr(`THRESHOLD_CODE_OFS_CTL, {16'h0, 1'b1, 2'h3, thr, 4'ha, 1'b0, 2'h1, 1'b1});
      wr(`THRESHOLD_CODE_OFS_FLAG, 32'h1);
      level <= 6'h00;
      wait_sig(sys_reset_req, 1'b1, 20000);
      rd(`THRESHOLD_CODE_OFS_CTL, {18'h0, 1'b1, 2'h0, thr, 4'ha, 1'b0, 2'h0, 1'b1});
      rd(`THRESHOLD_CODE_OFS_IEN, 34'h0);
      rd(`THRESHOLD_CODE_OFS_CLK, {18'h0, `THRESHOLD_CODE_CLK_RESET});
      @(negedge aclk);
      chk("route keep", {33'h0, ext_route_keep}, 34'h1);
      @(posedge aclk);
      level <= 6'h3f;
      wait_sig(sys_reset_req, 1'b0, 40);
      // Disable stops all sampling
      wr(`THRESHOLD_CODE_OFS_CTL, {16'h0, 1'b0, 2'h0, thr, 4'h0, 1'b0, 2'h0, 1'b0});
      repeat (4) @(posedge aclk);
      rd(`THRESHOLD_CODE_OFS_CTL, {18'h0, 3'h0, thr, 8'h0});
      wr(`THRESHOLD_CODE_OFS_FLAG, 32'h1);
      wr(`THRESHOLD_CODE_OFS_IEN, 32'h1);
      level <= 6'h00;
      n = 0;
      repeat (600) begin
         @(posedge aclk);
         if (det_power_on || irq_req) n++;
      end
      chk("stopped", 34'(n), 34'h0);
      // Debug halt gates the clock when debug run is off
      wr(`THRESHOLD_CODE_OFS_CLK, 32'h0);
      debug_halt <= 1'b1;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("clock gated", {33'h0, det_clk_run}, 34'h0);
      @(posedge aclk);
      debug_halt <= 1'b0;
      repeat (2) @(posedge aclk);
      // Relock, then a protected write must be ignored
      wr(`THRESHOLD_CODE_OFS_PROT, 32'h0);
      rd(`THRESHOLD_CODE_OFS_PROT, 34'h0);
      wr(`THRESHOLD_CODE_OFS_CTL, 32'h1);
      rd(`THRESHOLD_CODE_OFS_CTL, {18'h0, 3'h0, thr, 8'h0});
      summarize();
   end
endmodule
